// file: design/mcu_exec_map.vh
`ifndef MCU_EXEC_MAP_VH
`define MCU_EXEC_MAP_VH

// system register window for the immediate bank-zero store
`define SYS_LO 8'h80
`define SYS_HI 8'h87
`define PC_RESET 16'h0000

// opcode encoding
`define OP_LD_AM 6'h00
`define OP_ST_MA 6'h01
`define OP_B0_LD_AM 6'h02
`define OP_B0_ST_MA 6'h03
`define OP_LD_AI 6'h04
`define OP_B0_ST_MI 6'h05
`define OP_XCH 6'h06
`define OP_B0_XCH 6'h07
`define OP_TBL 6'h08
`define OP_ADC_AM 6'h09
`define OP_ADC_MA 6'h0A
`define OP_ADD_AM 6'h0B
`define OP_ADD_MA 6'h0C
`define OP_B0_ADD_MA 6'h0D
`define OP_ADD_AI 6'h0E
`define OP_SBC_AM 6'h0F
`define OP_SBC_MA 6'h10
`define OP_SUB_AM 6'h11
`define OP_SUB_MA 6'h12
`define OP_SUB_AI 6'h13
`define OP_DADJ 6'h14
`define OP_MULT 6'h15
`define OP_AND_AM 6'h16
`define OP_AND_MA 6'h17
`define OP_AND_AI 6'h18
`define OP_OR_AM 6'h19
`define OP_OR_MA 6'h1A
`define OP_OR_AI 6'h1B
`define OP_XOR_AM 6'h1C
`define OP_XOR_MA 6'h1D
`define OP_XOR_AI 6'h1E
`define OP_INV_A 6'h1F
`define OP_INV_M 6'h20
`define OP_NIB_A 6'h21
`define OP_NIB_M 6'h22
`define OP_BIT_CLR 6'h23
`define OP_BIT_SET 6'h24
`define OP_B0_BIT_CLR 6'h25
`define OP_B0_BIT_SET 6'h26
`define OP_CMP_AI 6'h27
`define OP_CMP_AM 6'h28
`define OP_INC_A_SK 6'h29
`define OP_INC_M_SK 6'h2A
`define OP_DEC_A_SK 6'h2B
`define OP_DEC_M_SK 6'h2C
`define OP_SK_CLR 6'h2D
`define OP_SK_SET 6'h2E
`define OP_B0_SK_CLR 6'h2F
`define OP_B0_SK_SET 6'h30
`define OP_ZTEST 6'h31
`define OP_GOTO 6'h32
`define OP_CALL 6'h33
`define OP_CALL_HL 6'h34

`endif

// file: design/mcu_instruction_execute.v
`timescale 1ns/1ps
`include "mcu_exec_map.vh"
// What this block does
// - immediate bank-zero store only to 0x80..0x87, literal written, no flags, 1 cycle.
// - bank-zero store forces bank 0, bank-zero load leaves mem_bank_o at bank_sel_i; load sets zero, store none; 1 cycle.
// - exchanges swap accumulator and memory byte, no flags, 1+N cycles.
// - table read puts ROM[Y,Z] high byte in R, low in accumulator; 2 cycles.
// - add-with-carry to accumulator updates carry, half-carry, zero; 1 cycle.
// - arithmetic written back to memory updates carry, half-carry, zero; 1+N cycles.
// - subtract-with-borrow uses inverted carry; borrow clears carry; 1 cycle.
// - plain subtract clears carry on borrow, sets otherwise; 1 cycle.
// - decimal adjust corrects accumulator to packed decimal, only carry; 1 cycle.
// - multiply: low byte to accumulator, high to R, zero from accumulator; 2 cycles.
// - AND, OR, XOR change zero only; 1 cycle to accumulator, 1+N to memory.
// - inversion writes ones' complement to accumulator or memory, zero updated, 1 cycle.
// - nibble exchange swaps halves, no flags; 1 cycle, in place 1+N.
// - bit clear and set touch one bit only, no flags, 1+N cycles.
// - compare updates zero and carry, skips when equal; 1+S cycles.
// - increment-and-skip, no flags, skip on zero; 1+S or 1+N+S cycles.
// - decrement-and-skip, skip on zero; in place 1+N+S cycles.
// - bit-test skips when bit matches tested value, no flags, 1+S cycles.
// - zero test sets zero flag from memory byte, byte kept, 1 cycle.
// - jump takes page bits into PC[15:14], operand into PC[13:0]; 2 cycles.
// - call pushes 16-bit PC+1 then targets as the jump; 2 cycles.
// - indirect call pushes PC+1, then PC gets H:L; 2 cycles.
// - N is 0 for a system register operand, 1 for data memory.
// - S is 1 when the skip condition holds, else 0.
module mcu_instruction_execute #(
    parameter STACK_DEPTH = 8,
    parameter SP_W = 3,
    parameter BANK_W = 2
) (
    // clock and reset
    input wire mclk_i,
    input wire reset_i,
    // instruction issue
    input wire exec_i,
    input wire [5:0] op_i,
    input wire [7:0] imm_i,
    input wire [2:0] bit_sel_i,
    input wire [13:0] target_i,
    output wire ready_o,
    output wire done_o,
    output wire [1:0] cycles_o,
    output wire skip_o,
    output wire reject_o,
    // operand memory
    input wire [7:0] mem_addr_i,
    input wire [7:0] mem_data_i,
    input wire mem_is_sys_i,
    input wire [BANK_W-1:0] bank_sel_i,
    output wire mem_we_o,
    output wire [7:0] mem_waddr_o,
    output wire [BANK_W-1:0] mem_bank_o,
    output wire [7:0] mem_wdata_o,
    // pointer and page registers
    input wire [1:0] program_page_bits_i,
    input wire [7:0] h_i,
    input wire [7:0] l_i,
    input wire [7:0] y_i,
    input wire [7:0] z_i,
    // program memory table port
    input wire [15:0] rom_data_i,
    output wire rom_rd_o,
    output wire [15:0] rom_addr_o,
    // core state
    output wire [7:0] acc_o,
    output wire [7:0] r_o,
    output wire carry_o,
    output wire half_carry_flag_o,
    output wire zero_result_flag_o,
    output wire [15:0] pc_o,
    output wire [SP_W:0] stack_level_o,
    output wire stack_ovf_o
);

////////////////////////////////////////////////////////////////////////////
function [9:0] add8;
    input [7:0] a;
    input [7:0] b;
    input ci;
    reg [4:0] lo;
    reg [8:0] full;
    begin
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        full = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        add8 = {full[8], lo[4], full[7:0]};
    end
endfunction

////////////////////////////////////////////////////////////////////////////
reg [7:0] acc_r, r_r, wdata_r, waddr_r;
reg c_r, h_r, z_r, we_r, done_r, skip_r, rej_r, rom_rd_r, tbl_r, ovf_r;
reg [1:0] wait_r, cyc_r;
reg [BANK_W-1:0] bank_r;
reg [15:0] pc_r, rom_addr_r;
reg [SP_W-1:0] sp_r;
reg [SP_W:0] level_r;
reg [15:0] stack_mem [0:STACK_DEPTH-1];

reg [7:0] b, val, acc_nxt, r_nxt, mask;
reg [9:0] res;
reg [15:0] prod, pc_nxt;
reg c_nxt, h_nxt, z_nxt, wr_acc, wr_mem, arith, logic_z, n_term;
reg skip, two, push, bank0, bad, tbl, hi, lo;
reg [1:0] cyc;

wire accept = exec_i & (wait_r == 2'd0);

always @* begin
    case (op_i)
        `OP_LD_AI, `OP_B0_ST_MI, `OP_ADD_AI, `OP_SUB_AI, `OP_AND_AI,
        `OP_OR_AI, `OP_XOR_AI, `OP_CMP_AI: b = imm_i;
        default: b = mem_data_i;
    endcase
    acc_nxt = acc_r;
    r_nxt = r_r;
    c_nxt = c_r;
    h_nxt = h_r;
    z_nxt = z_r;
    val = 8'h00;
    res = 10'h000;
    prod = 16'h0000;
    mask = 8'h01 << bit_sel_i;
    wr_acc = 1'b0;
    wr_mem = 1'b0;
    arith = 1'b0;
    logic_z = 1'b0;
    n_term = 1'b0;
    skip = 1'b0;
    two = 1'b0;
    push = 1'b0;
    bank0 = 1'b0;
    bad = 1'b0;
    tbl = 1'b0;
    hi = 1'b0;
    lo = 1'b0;
    pc_nxt = pc_r + 16'h0001;
    case (op_i)
        `OP_LD_AM, `OP_LD_AI: begin
            val = b;
            wr_acc = 1'b1;
            z_nxt = (op_i == `OP_LD_AM) ? (b == 8'h00) : z_r;
        end
        `OP_ST_MA: begin
            val = acc_r;
            wr_mem = 1'b1;
        end
        `OP_B0_LD_AM: begin
            val = b;
            wr_acc = 1'b1;
            z_nxt = (b == 8'h00);
        end
        `OP_B0_ST_MA: begin
            val = acc_r;
            wr_mem = 1'b1;
            bank0 = 1'b1;
        end
        `OP_B0_ST_MI: begin
            val = b;
            bank0 = 1'b1;
            bad = (mem_addr_i < `SYS_LO) | (mem_addr_i > `SYS_HI);
            wr_mem = ~bad;
        end
        `OP_XCH, `OP_B0_XCH: begin
            acc_nxt = b;
            val = acc_r;
            wr_mem = 1'b1;
            n_term = 1'b1;
            bank0 = (op_i == `OP_B0_XCH);
        end
        `OP_TBL: begin
            tbl = 1'b1;
            two = 1'b1;
        end
        `OP_ADC_AM, `OP_ADC_MA: begin
            res = add8(acc_r, b, c_r);
            arith = 1'b1;
        end
        `OP_ADD_AM, `OP_ADD_MA, `OP_B0_ADD_MA, `OP_ADD_AI: begin
            res = add8(acc_r, b, 1'b0);
            arith = 1'b1;
            bank0 = (op_i == `OP_B0_ADD_MA);
        end
        `OP_SBC_AM, `OP_SBC_MA: begin
            res = add8(acc_r, ~b, c_r);
            arith = 1'b1;
        end
        `OP_SUB_AM, `OP_SUB_MA, `OP_SUB_AI: begin
            res = add8(acc_r, ~b, 1'b1);
            arith = 1'b1;
        end
        `OP_DADJ: begin
            hi = (acc_r > 8'h99) | c_r;
            lo = (acc_r[3:0] > 4'h9) | h_r;
            val = acc_r + (hi ? 8'h60 : 8'h00) + (lo ? 8'h06 : 8'h00);
            wr_acc = 1'b1;
            c_nxt = hi;
        end
        `OP_MULT: begin
            prod = {8'h00, acc_r} * {8'h00, b};
            acc_nxt = prod[7:0];
            r_nxt = prod[15:8];
            z_nxt = (prod[7:0] == 8'h00);
            two = 1'b1;
        end
        `OP_AND_AM, `OP_AND_MA, `OP_AND_AI: begin
            val = acc_r & b;
            logic_z = 1'b1;
        end
        `OP_OR_AM, `OP_OR_MA, `OP_OR_AI: begin
            val = acc_r | b;
            logic_z = 1'b1;
        end
        `OP_XOR_AM, `OP_XOR_MA, `OP_XOR_AI: begin
            val = acc_r ^ b;
            logic_z = 1'b1;
        end
        `OP_INV_A, `OP_INV_M: begin
            val = ~b;
            z_nxt = (val == 8'h00);
            wr_acc = (op_i == `OP_INV_A);
            wr_mem = (op_i == `OP_INV_M);
        end
        `OP_NIB_A, `OP_NIB_M: begin
            val = {b[3:0], b[7:4]};
            wr_acc = (op_i == `OP_NIB_A);
            wr_mem = (op_i == `OP_NIB_M);
            n_term = wr_mem;
        end
        `OP_BIT_CLR, `OP_B0_BIT_CLR, `OP_BIT_SET, `OP_B0_BIT_SET: begin
            val = (op_i == `OP_BIT_SET || op_i == `OP_B0_BIT_SET) ?
                (b | mask) : (b & ~mask);
            wr_mem = 1'b1;
            n_term = 1'b1;
            bank0 = (op_i == `OP_B0_BIT_CLR) | (op_i == `OP_B0_BIT_SET);
        end
        `OP_CMP_AI, `OP_CMP_AM: begin
            res = add8(acc_r, ~b, 1'b1);
            c_nxt = res[9];
            z_nxt = (res[7:0] == 8'h00);
            skip = (acc_r == b);
        end
        `OP_INC_A_SK, `OP_INC_M_SK, `OP_DEC_A_SK, `OP_DEC_M_SK: begin
            val = (op_i == `OP_INC_A_SK || op_i == `OP_INC_M_SK) ?
                b + 8'h01 : b - 8'h01;
            wr_acc = (op_i == `OP_INC_A_SK) | (op_i == `OP_DEC_A_SK);
            wr_mem = ~wr_acc;
            n_term = wr_mem;
            skip = (val == 8'h00);
        end
        `OP_SK_CLR, `OP_SK_SET, `OP_B0_SK_CLR, `OP_B0_SK_SET: begin
            skip = (b[bit_sel_i] ==
                ((op_i == `OP_SK_SET) | (op_i == `OP_B0_SK_SET)));
            bank0 = (op_i == `OP_B0_SK_CLR) | (op_i == `OP_B0_SK_SET);
        end
        `OP_ZTEST: z_nxt = (b == 8'h00);
        `OP_GOTO, `OP_CALL: begin
            pc_nxt = {program_page_bits_i, target_i};
            push = (op_i == `OP_CALL);
            two = 1'b1;
        end
        `OP_CALL_HL: begin
            pc_nxt = {h_i, l_i};
            push = 1'b1;
            two = 1'b1;
        end
        default: begin
            val = 8'h00;
        end
    endcase
    if (arith) begin
        val = res[7:0];
        c_nxt = res[9];
        h_nxt = res[8];
        z_nxt = (res[7:0] == 8'h00);
    end
    if (arith | logic_z) begin
        z_nxt = (val == 8'h00);
        wr_mem = (op_i == `OP_ADC_MA) | (op_i == `OP_ADD_MA) |
            (op_i == `OP_B0_ADD_MA) | (op_i == `OP_SBC_MA) |
            (op_i == `OP_SUB_MA) | (op_i == `OP_AND_MA) |
            (op_i == `OP_OR_MA) | (op_i == `OP_XOR_MA);
        wr_acc = ~wr_mem;
        n_term = wr_mem;
    end
    if (wr_acc)
        acc_nxt = val;
    if (skip)
        pc_nxt = pc_r + 16'h0002;
    // cycle count 1+N+S, or 2 for the fixed two-cycle forms
    cyc = two ? 2'd2 : 2'd1 + {1'b0, n_term & ~mem_is_sys_i}
        + {1'b0, skip};
end

////////////////////////////////////////////////////////////////////////////
always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
        acc_r <= 8'h00;
        r_r <= 8'h00;
        c_r <= 1'b0;
        h_r <= 1'b0;
        z_r <= 1'b0;
        pc_r <= `PC_RESET;
        we_r <= 1'b0;
        wdata_r <= 8'h00;
        waddr_r <= 8'h00;
        bank_r <= {BANK_W{1'b0}};
        wait_r <= 2'd0;
        cyc_r <= 2'd0;
        done_r <= 1'b0;
        skip_r <= 1'b0;
        rej_r <= 1'b0;
        rom_rd_r <= 1'b0;
        rom_addr_r <= 16'h0000;
        tbl_r <= 1'b0;
        sp_r <= {SP_W{1'b0}};
        level_r <= {(SP_W+1){1'b0}};
        ovf_r <= 1'b0;
    end else begin
        we_r <= 1'b0;
        done_r <= 1'b0;
        skip_r <= 1'b0;
        rej_r <= 1'b0;
        rom_rd_r <= 1'b0;
        if (accept) begin
            acc_r <= acc_nxt;
            r_r <= r_nxt;
            c_r <= c_nxt;
            h_r <= h_nxt;
            z_r <= z_nxt;
            pc_r <= pc_nxt;
            we_r <= wr_mem;
            wdata_r <= val;
            waddr_r <= mem_addr_i;
            bank_r <= bank0 ? {BANK_W{1'b0}} : bank_sel_i;
            cyc_r <= cyc;
            wait_r <= cyc - 2'd1;
            done_r <= (cyc == 2'd1);
            skip_r <= skip;
            rej_r <= bad;
            rom_rd_r <= tbl;
            tbl_r <= tbl;
            rom_addr_r <= {y_i, z_i};
            if (push) begin
                sp_r <= sp_r + 1'b1;
                if (level_r == STACK_DEPTH[SP_W:0])
                    ovf_r <= 1'b1;
                else
                    level_r <= level_r + 1'b1;
            end
        end else if (wait_r != 2'd0) begin
            wait_r <= wait_r - 2'd1;
            done_r <= (wait_r == 2'd1);
            if (tbl_r) begin
                r_r <= rom_data_i[15:8];
                acc_r <= rom_data_i[7:0];
                tbl_r <= 1'b0;
            end
        end
    end
end

// return stack storage, oldest entry overwritten on overflow
always @(posedge mclk_i) begin
    if (accept && push)
        stack_mem[sp_r] <= pc_r + 16'h0001;
end

////////////////////////////////////////////////////////////////////////////
assign ready_o = (wait_r == 2'd0);
assign done_o = done_r;
assign cycles_o = cyc_r;
assign skip_o = skip_r;
assign reject_o = rej_r;
assign mem_we_o = we_r;
assign mem_waddr_o = waddr_r;
assign mem_bank_o = bank_r;
assign mem_wdata_o = wdata_r;
assign rom_rd_o = rom_rd_r;
assign rom_addr_o = rom_addr_r;
assign acc_o = acc_r;
assign r_o = r_r;
assign carry_o = c_r;
assign half_carry_flag_o = h_r;
assign zero_result_flag_o = z_r;
assign pc_o = pc_r;
assign stack_level_o = level_r;
assign stack_ovf_o = ovf_r;

endmodule // mcu_instruction_execute

// file: verif/exec_chk_sva.sv
`timescale 1ns/1ps
`include "mcu_exec_map.vh"
module exec_chk #(parameter BANK_W = 2) (
    // clock, reset and handshake
    input wire mclk_i, reset_i, exec_i, ready_o, done_o, skip_o, reject_o,
    // operand side
    input wire mem_is_sys_i, mem_we_o, rom_rd_o, carry_o,
    input wire half_carry_flag_o, zero_result_flag_o,
    input wire [5:0] op_i,
    input wire [7:0] imm_i, mem_addr_i, mem_data_i, h_i, l_i, y_i, z_i,
    input wire [2:0] bit_sel_i,
    input wire [13:0] target_i,
    input wire [1:0] program_page_bits_i,
    input wire [BANK_W-1:0] mem_bank_o,
    input wire [7:0] mem_wdata_o, acc_o,
    input wire [15:0] rom_addr_o, pc_o
);
    wire tk = exec_i && ready_o;
    wire in_win = mem_addr_i >= `SYS_LO && mem_addr_i <= `SYS_HI;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
////////////////////////////////////////////////////////////////////////////
    a_store_window_ok: assert property (tk && op_i == `OP_B0_ST_MI && in_win
        |=> mem_we_o && !reject_o && done_o && mem_wdata_o == $past(imm_i))
        else $error("system store inside window not written");
    a_store_window_bad: assert property (tk && op_i == `OP_B0_ST_MI && !in_win
        |=> reject_o && !mem_we_o) else $error("system store outside window");
    a_bank_zero_store: assert property (tk && op_i == `OP_B0_ST_MA
        |=> mem_we_o && mem_bank_o == 0 && mem_wdata_o == $past(acc_o))
        else $error("bank zero store wrong");
    a_table_read_seq: assert property (tk && op_i == `OP_TBL
        |=> rom_rd_o && !ready_o && rom_addr_o == {$past(y_i), $past(z_i)}
        ##1 done_o) else $error("table read sequence wrong");
    a_nibble_flags_kept: assert property (tk && op_i == `OP_NIB_A
        |=> $stable({carry_o, half_carry_flag_o, zero_result_flag_o})
        && acc_o == {$past(mem_data_i[3:0]), $past(mem_data_i[7:4])})
        else $error("nibble swap wrong");
    a_in_place_extra: assert property (tk && op_i == `OP_ADD_MA
        && !mem_is_sys_i |=> !done_o ##1 done_o)
        else $error("data memory extra cycle missing");
    a_bit_test_skip: assert property (tk && op_i == `OP_SK_SET
        |=> skip_o == $past(mem_data_i[bit_sel_i]))
        else $error("bit test skip wrong");
    a_goto_target: assert property (tk && op_i == `OP_GOTO
        |=> pc_o == {$past(program_page_bits_i), $past(target_i)})
        else $error("jump target wrong");
    a_pair_call_target: assert property (tk && op_i == `OP_CALL_HL
        |=> pc_o == {$past(h_i), $past(l_i)}) else $error("pair call wrong");
    c_table: cover property (tk && op_i == `OP_TBL);
    c_skip: cover property (skip_o);
    c_reject: cover property (reject_o);
endmodule // exec_chk
////////////////////////////////////////////////////////////////////////////
bind mcu_instruction_execute exec_chk #(.BANK_W(BANK_W)) u_chk (
    .mclk_i(mclk_i), .reset_i(reset_i), .exec_i(exec_i), .ready_o(ready_o),
    .done_o(done_o), .skip_o(skip_o), .reject_o(reject_o),
    .mem_is_sys_i(mem_is_sys_i), .mem_we_o(mem_we_o), .rom_rd_o(rom_rd_o),
    .carry_o(carry_o), .half_carry_flag_o(half_carry_flag_o),
    .zero_result_flag_o(zero_result_flag_o), .op_i(op_i), .imm_i(imm_i),
    .mem_addr_i(mem_addr_i), .mem_data_i(mem_data_i), .h_i(h_i), .l_i(l_i),
    .y_i(y_i), .z_i(z_i), .bit_sel_i(bit_sel_i), .target_i(target_i),
    .program_page_bits_i(program_page_bits_i), .mem_bank_o(mem_bank_o),
    .mem_wdata_o(mem_wdata_o), .acc_o(acc_o), .rom_addr_o(rom_addr_o),
    .pc_o(pc_o));

// file: verif/testbench.sv
`timescale 1ns/1ps
`include "mcu_exec_map.vh"
module testbench;
    reg mclk_i = 1'h0;
    reg reset_i = 1'h1;
    reg exec_i = 1'h0;
    reg [5:0] op_i = 6'h0;
    reg [7:0] imm_i = 8'h0, mem_addr_i = 8'h0, mem_data_i = 8'h0;
    reg [2:0] bit_sel_i = 3'h0;
    reg [1:0] bank_sel_i = 2'h3;
    reg [15:0] rom_data_i = 16'h0000;
    wire ready_o, done_o, skip_o, reject_o, mem_we_o, rom_rd_o;
    wire carry_o, half_carry_flag_o, zero_result_flag_o, stack_ovf_o;
    wire [1:0] cycles_o, mem_bank_o;
    wire [7:0] mem_wdata_o, mem_waddr_o, acc_o, r_o;
    wire [15:0] rom_addr_o, pc_o;
    wire [3:0] stack_level_o;
    wire [2:0] flags = {carry_o, half_carry_flag_o, zero_result_flag_o};
    integer mismatches = 0;
    integer comparisons = 0;
    integer j;
    reg [15:0] p;
    always #5 mclk_i = ~mclk_i;
    mcu_instruction_execute DUT (.mclk_i(mclk_i), .reset_i(reset_i),
        .exec_i(exec_i), .op_i(op_i), .imm_i(imm_i), .bit_sel_i(bit_sel_i),
        .target_i({6'h2A, imm_i}), .ready_o(ready_o), .done_o(done_o),
        .cycles_o(cycles_o), .skip_o(skip_o), .reject_o(reject_o),
        .mem_addr_i(mem_addr_i), .mem_data_i(mem_data_i),
        .mem_is_sys_i(mem_addr_i[7]), .bank_sel_i(bank_sel_i),
        .mem_we_o(mem_we_o), .mem_waddr_o(mem_waddr_o),
        .mem_bank_o(mem_bank_o), .mem_wdata_o(mem_wdata_o),
        .program_page_bits_i(2'h2), .h_i(8'h56), .l_i(8'h78), .y_i(8'h12),
        .z_i(8'h34), .rom_data_i(rom_data_i), .rom_rd_o(rom_rd_o),
        .rom_addr_o(rom_addr_o), .acc_o(acc_o), .r_o(r_o), .carry_o(carry_o),
        .half_carry_flag_o(half_carry_flag_o),
        .zero_result_flag_o(zero_result_flag_o), .pc_o(pc_o),
        .stack_level_o(stack_level_o), .stack_ovf_o(stack_ovf_o));
////////////////////////////////////////////////////////////////////////////
    task report_and_stop;
        begin
            $display("mismatches %0d comparisons %0d", mismatches, comparisons);
            if (mismatches == 0 && comparisons > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task check(input [23:0] seen, input [23:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("Error at %0t: saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // issue one instruction, count cycles up to done
    task run(input [5:0] o, input [7:0] a, d, i, input [2:0] b,
        input [1:0] n);
        integer k;
        begin
            @(posedge mclk_i);
            op_i <= o;
            mem_addr_i <= a;
            mem_data_i <= d;
            imm_i <= i;
            bit_sel_i <= b;
            exec_i <= 1'h1;
            @(posedge mclk_i);
            exec_i <= 1'h0;
            #1;
            k = 1;
            while (done_o !== 1'h1 && k < 5) begin
                @(posedge mclk_i);
                #1;
                k = k + 1;
            end
            if (k == 5) begin
                mismatches = mismatches + 1;
                report_and_stop;
            end else begin
                check(k, n);
                check(cycles_o, n);
            end
        end
    endtask
////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge mclk_i);
        reset_i <= 1'h0;
        run(`OP_LD_AI, 8'h0, 8'h0, 8'h99, 3'h0, 2'h1);
        run(`OP_ADD_AI, 8'h0, 8'h0, 8'h01, 3'h0, 2'h1);
        run(`OP_DADJ, 8'h0, 8'h0, 8'h0, 3'h0, 2'h1);
        check(acc_o, 16'h0);
        check(flags, 16'h4);
        run(`OP_LD_AI, 8'h0, 8'h0, 8'h0F, 3'h0, 2'h1);
        run(`OP_ADC_AM, 8'h10, 8'hF0, 8'h0, 3'h0, 2'h1);
        check({flags, acc_o}, 16'h700);
        run(`OP_LD_AI, 8'h0, 8'h0, 8'h10, 3'h0, 2'h1);
        run(`OP_SUB_AI, 8'h0, 8'h0, 8'h20, 3'h0, 2'h1);
        check({flags, acc_o}, 16'h2F0);
        run(`OP_SBC_AM, 8'h10, 8'h01, 8'h0, 3'h0, 2'h1);
        check({flags, acc_o}, 16'h4EE);
        run(`OP_MULT, 8'h10, 8'h12, 8'h0, 3'h0, 2'h2);
        check({r_o, acc_o}, 16'h10BC);
        check(flags, 16'h4);
        run(`OP_ADD_MA, 8'h10, 8'h44, 8'h0, 3'h0, 2'h2);
        check({flags, mem_wdata_o, acc_o}, 24'h0700BC);
        run(`OP_ADD_MA, 8'h85, 8'h01, 8'h0, 3'h0, 2'h1);
        check({flags, mem_wdata_o}, 16'hBD);
        run(`OP_XCH, 8'h20, 8'h5A, 8'h0, 3'h0, 2'h2);
        check({flags, mem_wdata_o, acc_o}, 16'hBC5A);
        for (j = 0; j < 3; j = j + 1) begin
            run(`OP_LD_AI, 8'h0, 8'h0, 8'hF0, 3'h0, 2'h1);
            run(`OP_AND_AI + 6'h3 * j[5:0], 8'h0, 8'h0, 8'h0F, 3'h0,
                2'h1);
            check({flags, acc_o}, j == 0 ? 16'h100 : 16'hFF);
        end
        run(`OP_NIB_M, 8'h30, 8'hA5, 8'h0, 3'h0, 2'h2);
        check({flags, mem_wdata_o}, 16'h5A);
        run(`OP_NIB_A, 8'h30, 8'hC3, 8'h0, 3'h0, 2'h1);
        check({flags, acc_o}, 16'h3C);
        run(`OP_INV_M, 8'h30, 8'hA5, 8'h0, 3'h0, 2'h1);
        check({flags, mem_wdata_o}, 16'h5A);
        run(`OP_INV_A, 8'h30, 8'hFF, 8'h0, 3'h0, 2'h1);
        check({flags, acc_o}, 16'h100);
        run(`OP_BIT_SET, 8'h30, 8'h00, 8'h0, 3'h7, 2'h2);
        check({flags, mem_wdata_o}, 16'h180);
        run(`OP_B0_BIT_CLR, 8'h85, 8'hFF, 8'h0, 3'h0, 2'h1);
        check({mem_bank_o, mem_wdata_o}, 16'hFE);
        run(`OP_LD_AI, 8'h0, 8'h0, 8'h3C, 3'h0, 2'h1);
        p = pc_o;
        run(`OP_CMP_AI, 8'h0, 8'h0, 8'h3C, 3'h0, 2'h2);
        check({flags, pc_o - p}, 24'h050002);
        run(`OP_CMP_AI, 8'h0, 8'h0, 8'h3D, 3'h0, 2'h1);
        check(flags, 16'h0);
        run(`OP_INC_M_SK, 8'h30, 8'hFF, 8'h0, 3'h0, 2'h3);
        check({flags, mem_wdata_o}, 16'h0);
        run(`OP_INC_A_SK, 8'h30, 8'h05, 8'h0, 3'h0, 2'h1);
        check({flags, acc_o}, 16'h06);
        run(`OP_DEC_M_SK, 8'h30, 8'h01, 8'h0, 3'h0, 2'h3);
        run(`OP_DEC_A_SK, 8'h30, 8'h01, 8'h0, 3'h0, 2'h2);
        check(acc_o, 16'h0);
        run(`OP_SK_CLR, 8'h30, 8'hF7, 8'h0, 3'h3, 2'h2);
        run(`OP_SK_SET, 8'h30, 8'hF7, 8'h0, 3'h3, 2'h1);
        run(`OP_B0_SK_SET, 8'h30, 8'h08, 8'h0, 3'h3, 2'h2);
        run(`OP_ZTEST, 8'h30, 8'h00, 8'h0, 3'h0, 2'h1);
        check(flags, 16'h1);
        run(`OP_B0_ST_MI, 8'h87, 8'h0, 8'h33, 3'h0, 2'h1);
        check({mem_we_o, mem_bank_o, mem_waddr_o, mem_wdata_o},
            24'h048733);
        run(`OP_B0_ST_MI, 8'h88, 8'h0, 8'h44, 3'h0, 2'h1);
        check({reject_o, mem_we_o}, 16'h2);
        run(`OP_B0_LD_AM, 8'h40, 8'h7E, 8'h0, 3'h0, 2'h1);
        check({flags, acc_o}, 16'h7E);
        run(`OP_B0_ST_MA, 8'h40, 8'h0, 8'h0, 3'h0, 2'h1);
        check({mem_bank_o, mem_wdata_o}, 16'h7E);
        @(posedge mclk_i);
        bank_sel_i <= 2'h1;
        rom_data_i <= 16'hA55A;
        run(`OP_ST_MA, 8'h41, 8'h0, 8'h0, 3'h0, 2'h1);
        check({mem_bank_o, mem_wdata_o}, 16'h17E);
        run(`OP_B0_XCH, 8'h42, 8'h00, 8'h0, 3'h0, 2'h2);
        check({mem_bank_o, mem_wdata_o, acc_o}, 24'h007E00);
        run(`OP_B0_ADD_MA, 8'h43, 8'h00, 8'h0, 3'h0, 2'h2);
        check({flags, mem_bank_o, mem_wdata_o}, 16'h400);
        run(`OP_TBL, 8'h0, 8'h0, 8'h0, 3'h0, 2'h2);
        check({r_o, acc_o}, 16'hA55A);
        run(`OP_GOTO, 8'h0, 8'h0, 8'hBC, 3'h0, 2'h2);
        check(pc_o, 16'hAABC);
        run(`OP_CALL, 8'h0, 8'h0, 8'h00, 3'h0, 2'h2);
        check({stack_level_o, pc_o}, 20'h1AA00);
        run(`OP_CALL_HL, 8'h0, 8'h0, 8'h0, 3'h0, 2'h2);
        check({stack_level_o, pc_o}, 20'h25678);
        for (j = 0; j < 7; j = j + 1)
            run(`OP_CALL_HL, 8'h0, 8'h0, 8'h0, 3'h0, 2'h2);
        check({stack_ovf_o, stack_level_o}, 16'h18);
        report_and_stop;
    end
endmodule // testbench
